// ### design/spcc_pkg.sv
/*
 * Shared constants and carriers for the serial port clock source and
 * channel select block: register offsets, field positions, reset values
 * and the structs that carry configuration across clock domains.
 * Assumes a 16-bit register port with byte addresses on 8 bits.
 */
package spcc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int NUM_PART = 8;
    localparam int PART_CH = 16;
    localparam int CHAN_W = 7;
    localparam int WORD_BITS = 8;

    // Register byte addresses
    localparam logic [7:0] OFF_PIN_CONTROL = 8'h00;
    localparam logic [7:0] OFF_RATE_GEN_TWO = 8'h04;
    localparam logic [7:0] OFF_RX_MC_CTRL = 8'h08;
    localparam logic [7:0] OFF_TX_MC_CTRL = 8'h0c;
    localparam logic [7:0] OFF_RX_ENABLE = 8'h10;
    localparam logic [7:0] OFF_TX_ENABLE = 8'h30;
    localparam logic [7:0] OFF_ENABLE_SPAN = 8'h20;

    // pin_control fields
    localparam int PC_RX_IO_EN = 12;
    localparam int PC_TX_FS_MODE = 11;
    localparam int PC_RX_FS_MODE = 10;
    localparam int PC_TX_CLK_MODE = 9;
    localparam int PC_RX_CLK_MODE = 8;
    localparam int PC_ENH_CLK_MODE = 7;
    localparam int PC_EXT_CLK_STAT = 6;
    localparam int PC_RX_DATA_STAT = 4;
    localparam logic [15:0] PC_RW_MASK = 16'h1f8f;

    // rate_gen_reg_two fields
    localparam int RG_GEN_CLK_MODE = 13;

    // Multichannel control fields (same layout both directions)
    localparam int MC_EXT = 9;
    localparam int MC_PB_LSB = 7;
    localparam int MC_PA_LSB = 5;
    localparam int MC_CUR_LSB = 2;
    localparam int MC_MODE_LSB = 0;
    localparam logic [15:0] MC_RW_MASK = 16'h03e3;

    localparam logic [15:0] RESET_VAL = 16'h0000;

    // Generator source codes {enhanced_sample_clock_mode, gen_clock_mode}
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_CPU = 2'h1;
    localparam logic [1:0] SRC_RX_PIN = 2'h2;
    localparam logic [1:0] SRC_TX_PIN = 2'h3;

    typedef struct packed {
        logic                            ext;
        logic [1:0]                      mode;
        logic [1:0]                      pa;
        logic [1:0]                      pb;
        logic [NUM_PART-1:0][PART_CH-1:0] en;
    } spcc_dir_cfg_s;

    typedef struct packed {
        spcc_dir_cfg_s tx;
        spcc_dir_cfg_s rx;
    } spcc_link_cfg_s;

    typedef struct packed {
        logic       o;
        logic       oe_n;
    } spcc_pin_drv_s;

endpackage

// ### design/spcc_sync2.sv
/*
 * Two flip-flop synchroniser of configurable width.
 * Assumes the input is a level or a gray-coded value stable for
 * several destination clocks; resets synchronously, active low.
 */
module spcc_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset of the destination domain
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// ### design/spcc_top.sv
/*
 * Serial port clock source select and multichannel channel select.
 * Holds the control registers, steers the generator source and the
 * two bidirectional clock pin drivers, and runs a channel counter on
 * the link clock that flags enabled channels for both directions.
 * Assumes the sample rate generator and the shift logic sit outside.
 */
// The address-and-strobe port and the address map were left to the implementer.
module spcc_top (
    // System clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Register port
    input  wire logic [spcc_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [spcc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [spcc_pkg::DATA_W-1:0] reg_rdata,
    // Generator interface
    input  wire logic                        gen_clk_out,
    output logic      [1:0]                  gen_src_sel,
    output logic                             gen_src_valid,
    // Clock pins
    input  wire logic                        rx_clk_i,
    output logic                             rx_clk_o,
    output logic                             rx_clk_oe_n,
    input  wire logic                        tx_clk_i,
    output logic                             tx_clk_o,
    output logic                             tx_clk_oe_n,
    // Receive data pin
    input  wire logic                        rx_data_i,
    // Link side
    input  wire logic                        link_clk,
    input  wire logic                        link_fs,
    output logic                             tx_chan_active,
    output logic                             rx_chan_active,
    output logic      [spcc_pkg::CHAN_W-1:0] link_chan
);

    typedef struct packed {
        logic [15:0]                          pc;
        logic [15:0]                          rg2;
        logic [15:0]                          rmc;
        logic [15:0]                          tmc;
        logic [spcc_pkg::NUM_PART-1:0][15:0]  rx_en;
        logic [spcc_pkg::NUM_PART-1:0][15:0]  tx_en;
        logic [15:0]                          rdata;
        logic [1:0]                           src;
        logic                                 src_ok;
        spcc_pkg::spcc_pin_drv_s              rxp;
        spcc_pkg::spcc_pin_drv_s              txp;
    } spcc_sys_s;

    typedef struct packed {
        logic [4:0]                  bit_cnt;
        logic [spcc_pkg::CHAN_W-1:0] chan;
        logic [2:0]                  blk_gray;
        logic                        tx_act;
        logic                        rx_act;
    } spcc_link_s;

    function automatic logic chan_on(input spcc_pkg::spcc_dir_cfg_s c,
                                     input logic [spcc_pkg::CHAN_W-1:0] ch);
        logic [2:0] blk;
        blk = ch[6:4];
        if (c.mode == 2'h0) begin
            chan_on = 1'b1;
        end else if (c.ext) begin
            chan_on = c.en[blk][ch[3:0]];
        end else if (blk == {c.pa, 1'b0}) begin
            chan_on = c.en[0][ch[3:0]];
        end else if (blk == {c.pb, 1'b1}) begin
            chan_on = c.en[1][ch[3:0]];
        end else begin
            chan_on = 1'b0;
        end
    endfunction

    function automatic logic [2:0] gray2bin(input logic [2:0] g);
        gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
    endfunction

    spcc_sys_s                st_r;
    spcc_sys_s                st_nxt;
    spcc_link_s               lk_r;
    spcc_link_s               lk_nxt;
    spcc_pkg::spcc_link_cfg_s cfg_sys;
    spcc_pkg::spcc_link_cfg_s cfg_lk;
    logic [2:0]               pin_sync;
    logic [2:0]               blk_gray_sys;
    logic                     link_rst_n;

    // Pin levels into the system domain
    spcc_sync2 #(.WIDTH(3)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({rx_data_i, tx_clk_i, rx_clk_i}),
        .q     (pin_sync)
    );

    // Current block back from the link domain, gray coded
    spcc_sync2 #(.WIDTH(3)) u_blk_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (lk_r.blk_gray),
        .q     (blk_gray_sys)
    );

    // Reset into the link domain
    spcc_sync2 #(.WIDTH(1)) u_lrst_sync (
        .clk   (link_clk),
        .rst_n (1'b1),
        .d     (rst_n),
        .q     (link_rst_n)
    );

    // Quasi-static channel configuration into the link domain
    spcc_sync2 #(.WIDTH($bits(spcc_pkg::spcc_link_cfg_s))) u_cfg_sync (
        .clk   (link_clk),
        .rst_n (link_rst_n),
        .d     (cfg_sys),
        .q     (cfg_lk)
    );

    always_comb begin
        cfg_sys.tx.ext  = st_r.tmc[spcc_pkg::MC_EXT];
        cfg_sys.tx.mode = st_r.tmc[spcc_pkg::MC_MODE_LSB +: 2];
        cfg_sys.tx.pa   = st_r.tmc[spcc_pkg::MC_PA_LSB +: 2];
        cfg_sys.tx.pb   = st_r.tmc[spcc_pkg::MC_PB_LSB +: 2];
        cfg_sys.tx.en   = st_r.tx_en;
        cfg_sys.rx.ext  = st_r.rmc[spcc_pkg::MC_EXT];
        cfg_sys.rx.mode = st_r.rmc[spcc_pkg::MC_MODE_LSB +: 2];
        cfg_sys.rx.pa   = st_r.rmc[spcc_pkg::MC_PA_LSB +: 2];
        cfg_sys.rx.pb   = st_r.rmc[spcc_pkg::MC_PB_LSB +: 2];
        cfg_sys.rx.en   = st_r.rx_en;
    end

    // System domain: registers and pin steering
    always_comb begin
        logic [15:0] rd;
        logic [7:0]  idx;
        logic        rx_src;
        logic        tx_src;
        rd     = spcc_pkg::RESET_VAL;
        idx    = 8'h00;
        rx_src = 1'b0;
        tx_src = 1'b0;
        st_nxt = st_r;
        if (reg_wr) begin
            if (reg_addr == spcc_pkg::OFF_PIN_CONTROL) begin
                st_nxt.pc = reg_wdata & spcc_pkg::PC_RW_MASK;
            end else if (reg_addr == spcc_pkg::OFF_RATE_GEN_TWO) begin
                st_nxt.rg2 = reg_wdata;
            end else if (reg_addr == spcc_pkg::OFF_RX_MC_CTRL) begin
                st_nxt.rmc = reg_wdata & spcc_pkg::MC_RW_MASK;
            end else if (reg_addr == spcc_pkg::OFF_TX_MC_CTRL) begin
                st_nxt.tmc = reg_wdata & spcc_pkg::MC_RW_MASK;
            end else if (reg_addr >= spcc_pkg::OFF_RX_ENABLE
                         && reg_addr < spcc_pkg::OFF_TX_ENABLE) begin
                idx = reg_addr - spcc_pkg::OFF_RX_ENABLE;
                if (idx[1:0] == 2'h0) begin
                    st_nxt.rx_en[idx[4:2]] = reg_wdata;
                end
            end else if (reg_addr >= spcc_pkg::OFF_TX_ENABLE
                         && reg_addr < spcc_pkg::OFF_TX_ENABLE + spcc_pkg::OFF_ENABLE_SPAN) begin
                idx = reg_addr - spcc_pkg::OFF_TX_ENABLE;
                if (idx[1:0] == 2'h0) begin
                    st_nxt.tx_en[idx[4:2]] = reg_wdata;
                end
            end
        end
        if (reg_addr == spcc_pkg::OFF_PIN_CONTROL) begin
            rd = st_r.pc;
            rd[spcc_pkg::PC_EXT_CLK_STAT] = (st_r.src == spcc_pkg::SRC_RX_PIN) ? pin_sync[0]
                : (st_r.src == spcc_pkg::SRC_TX_PIN) ? pin_sync[1] : 1'b0;
            rd[spcc_pkg::PC_RX_DATA_STAT] = pin_sync[2];
        end else if (reg_addr == spcc_pkg::OFF_RATE_GEN_TWO) begin
            rd = st_r.rg2;
        end else if (reg_addr == spcc_pkg::OFF_RX_MC_CTRL) begin
            rd = st_r.rmc;
        end else if (reg_addr == spcc_pkg::OFF_TX_MC_CTRL) begin
            rd = st_r.tmc;
            rd[spcc_pkg::MC_CUR_LSB +: 3] = gray2bin(blk_gray_sys);
        end else if (reg_addr >= spcc_pkg::OFF_RX_ENABLE
                     && reg_addr < spcc_pkg::OFF_TX_ENABLE) begin
            idx = reg_addr - spcc_pkg::OFF_RX_ENABLE;
            rd = (idx[1:0] == 2'h0) ? st_r.rx_en[idx[4:2]] : spcc_pkg::RESET_VAL;
        end else if (reg_addr >= spcc_pkg::OFF_TX_ENABLE
                     && reg_addr < spcc_pkg::OFF_TX_ENABLE + spcc_pkg::OFF_ENABLE_SPAN) begin
            idx = reg_addr - spcc_pkg::OFF_TX_ENABLE;
            rd = (idx[1:0] == 2'h0) ? st_r.tx_en[idx[4:2]] : spcc_pkg::RESET_VAL;
        end
        st_nxt.rdata = reg_rd ? rd : spcc_pkg::RESET_VAL;
        // Source select and pin drivers follow the stored bits
        st_nxt.src = {st_r.pc[spcc_pkg::PC_ENH_CLK_MODE],
                      st_r.rg2[spcc_pkg::RG_GEN_CLK_MODE]};
        st_nxt.src_ok = (st_nxt.src != spcc_pkg::SRC_EXT);
        rx_src = (st_nxt.src == spcc_pkg::SRC_RX_PIN);
        tx_src = (st_nxt.src == spcc_pkg::SRC_TX_PIN);
        st_nxt.rxp.oe_n = rx_src || !st_r.pc[spcc_pkg::PC_RX_CLK_MODE];
        st_nxt.txp.oe_n = tx_src || !st_r.pc[spcc_pkg::PC_TX_CLK_MODE];
        st_nxt.rxp.o = gen_clk_out;
        st_nxt.txp.o = gen_clk_out;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.rxp.oe_n <= 1'b1;
            st_r.txp.oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Link domain: channel counter and enable lookup
    always_comb begin
        lk_nxt = lk_r;
        if (link_fs) begin
            lk_nxt.bit_cnt = '0;
            lk_nxt.chan = '0;
        end else if (lk_r.bit_cnt == 5'(spcc_pkg::WORD_BITS - 1)) begin
            lk_nxt.bit_cnt = '0;
            lk_nxt.chan = lk_r.chan + 7'h01;
        end else begin
            lk_nxt.bit_cnt = lk_r.bit_cnt + 5'h01;
        end
        lk_nxt.blk_gray = lk_nxt.chan[6:4] ^ {1'b0, lk_nxt.chan[6:5]};
        lk_nxt.tx_act = chan_on(cfg_lk.tx, lk_nxt.chan);
        lk_nxt.rx_act = chan_on(cfg_lk.rx, lk_nxt.chan);
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    assign reg_rdata      = st_r.rdata;
    assign gen_src_sel    = st_r.src;
    assign gen_src_valid  = st_r.src_ok;
    assign rx_clk_o       = st_r.rxp.o;
    assign rx_clk_oe_n    = st_r.rxp.oe_n;
    assign tx_clk_o       = st_r.txp.o;
    assign tx_clk_oe_n    = st_r.txp.oe_n;
    assign tx_chan_active = lk_r.tx_act;
    assign rx_chan_active = lk_r.rx_act;
    assign link_chan      = lk_r.chan;

    chk_src_select: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> gen_src_sel == {$past(st_r.pc[7]), $past(st_r.rg2[13])})
        else $error("generator source does not follow control bits");
    chk_enh_bit_wr: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == spcc_pkg::OFF_PIN_CONTROL
        |=> st_r.pc[spcc_pkg::PC_ENH_CLK_MODE] == $past(reg_wdata[7]))
        else $error("enhanced clock mode bit not written");
    chk_gen_mode_rd: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == spcc_pkg::OFF_RATE_GEN_TWO ##1 reg_rd
        && reg_addr == spcc_pkg::OFF_RATE_GEN_TWO && !reg_wr
        |=> reg_rdata[13] == $past(reg_wdata[13], 2))
        else $error("generator clock mode bit readback wrong");
    chk_rx_pin_off: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.pc[7] && !st_r.rg2[13] |=> rx_clk_oe_n)
        else $error("receive clock pin driven while used as input");
    chk_tx_pin_off: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.pc[7] && st_r.rg2[13] |=> tx_clk_oe_n)
        else $error("transmit clock pin driven while used as input");
    chk_tx_only_drive: assert property (@(posedge clk) disable iff (!rst_n)
        st_r.pc[7] && !st_r.rg2[13] && st_r.pc[9] && st_r.pc[8]
        |=> !tx_clk_oe_n && rx_clk_oe_n && tx_clk_o == $past(gen_clk_out))
        else $error("generator output not on transmit pin only");
    chk_status_ro: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == spcc_pkg::OFF_PIN_CONTROL
        |=> reg_rdata[4] == $past(pin_sync[2]) && reg_rdata[5] == 1'b0)
        else $error("receive data status bit wrong");
    chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == spcc_pkg::OFF_TX_MC_CTRL |=> reg_rdata[15:10] == 6'h00)
        else $error("reserved multichannel bits not zero");
    chk_frame_restart: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        link_fs |=> link_chan == 7'h00 ##8 link_chan == 7'h01)
        else $error("channel count not restarted by frame sync");
    chk_part_ab_only: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        !cfg_lk.rx.ext && cfg_lk.rx.mode != 2'h0 && $stable(cfg_lk)
        && lk_nxt.chan[6:4] != {cfg_lk.rx.pa, 1'b0} && lk_nxt.chan[6:4] != {cfg_lk.rx.pb, 1'b1}
        |=> !rx_chan_active)
        else $error("channel outside partitions A and B enabled");

    cov_rx_pin_src: cover property (@(posedge clk) disable iff (!rst_n)
        gen_src_sel == spcc_pkg::SRC_RX_PIN && !tx_clk_oe_n);
    cov_tx_pin_src: cover property (@(posedge clk) disable iff (!rst_n)
        gen_src_sel == spcc_pkg::SRC_TX_PIN);
    cov_wide_chan: cover property (@(posedge link_clk) disable iff (!link_rst_n)
        cfg_lk.tx.ext && tx_chan_active && link_chan[6]);

endmodule

// ### tb/spcc_codec_model.sv
/*
 * Far-side serial device: frames of 128 eight-bit words on the link.
 * Assumes the bench raises run to ask for frames; the link clock stands
 * still between frames except for two lead-in clocks before each, and the frame sync marks the first bit.
 */
module spcc_codec_model #(
    parameter int FRAME_EDGES = 1024,
    parameter int HALF_NS     = 32
) (
    // Bench control
    input  wire logic run,
    // Link toward the port
    output logic      link_clk,
    output logic      link_fs,
    output logic      rx_data,
    output logic      in_frame
);
    timeunit 1ns;
    timeprecision 100ps;

    // Whole frames only; run is looked at between frames
    initial begin
        link_clk = 1'b0;
        link_fs  = 1'b0;
        rx_data  = 1'b0;
        in_frame = 1'b0;
        #7;
        forever begin
            if (run !== 1'b1) begin
                #(HALF_NS);
            end else begin
                // Two lead-in clocks let settings reach the link side
                repeat (2) begin
                    #(HALF_NS) link_clk = 1'b1;
                    #(HALF_NS) link_clk = 1'b0;
                end
                in_frame = 1'b1;
                for (int i = 0; i < FRAME_EDGES; i++) begin
                    link_fs = (i == 0);
                    #(HALF_NS) link_clk = 1'b1;
                    #(HALF_NS) link_clk = 1'b0;
                    rx_data = ~rx_data;
                end
                link_fs  = 1'b0;
                in_frame = 1'b0;
            end
        end
    end
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench for the clock source and channel select block.
 * Assumes the codec model drives the link; clock pins resolve from enables.
 */
module tb;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] rg;
        logic [1:0]  sel;
        logic        vld;
        logic        rx_oe_n;
        logic        tx_oe_n;
    } spcc_row_s;

    logic         clk, rst_n, reg_wr, reg_rd, gen_clk_out, run, arm, chk_on;
    logic [7:0]   reg_addr;
    logic [15:0]  reg_wdata, reg_rdata, d, tx_mc, rx_mc;
    logic [1:0]   gen_src_sel;
    logic         gen_src_valid, rx_clk_o, rx_clk_oe_n, tx_clk_o, tx_clk_oe_n;
    logic         link_clk, link_fs, rx_data, in_frame, tx_chan_active, rx_chan_active;
    logic [6:0]   link_chan, ch;
    logic [2:0]   bc;
    logic [127:0] tx_en, rx_en;
    wire          rx_pin = rx_clk_oe_n ? link_clk : rx_clk_o;
    wire          tx_pin = tx_clk_oe_n ? link_clk : tx_clk_o;
    int           fails, tests_run;
    spcc_row_s    rows [5];

    spcc_top dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gen_clk_out(gen_clk_out),
        .gen_src_sel(gen_src_sel), .gen_src_valid(gen_src_valid), .rx_clk_i(rx_pin),
        .rx_clk_o(rx_clk_o), .rx_clk_oe_n(rx_clk_oe_n), .tx_clk_i(tx_pin),
        .tx_clk_o(tx_clk_o), .tx_clk_oe_n(tx_clk_oe_n), .rx_data_i(rx_data),
        .link_clk(link_clk), .link_fs(link_fs), .tx_chan_active(tx_chan_active),
        .rx_chan_active(rx_chan_active), .link_chan(link_chan));

    spcc_codec_model codec (.run(run), .link_clk(link_clk), .link_fs(link_fs),
        .rx_data(rx_data), .in_frame(in_frame));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) gen_clk_out <= ~gen_clk_out;

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk);
    endtask

    task automatic wr_en(input logic tx, input logic [2:0] p, input logic [15:0] v);
        if (tx) tx_en[{p, 4'h0} +: 16] = v;
        else rx_en[{p, 4'h0} +: 16] = v;
        wr((tx ? spcc_pkg::OFF_TX_ENABLE : spcc_pkg::OFF_RX_ENABLE) + {3'h0, p, 2'h0}, v);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (in_frame !== 1'b0 && n < 10000) begin
            @(posedge clk);
            n++;
        end
        if (n == 10000) begin
            fails++;
            give_verdict();
        end
    endtask

    task automatic run_frame(input string nm);
        int n;
        n = 0;
        arm <= 1'b1;
        run <= 1'b1;
        while (in_frame !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        run <= 1'b0;
        if (n == 2000) begin
            fails++;
            give_verdict();
        end
        wait_idle();
        arm <= 1'b0;
        $display("Test %s done", nm);
    endtask

    function automatic logic exp_act(input logic [15:0] mc, input logic [127:0] en,
                                     input logic [6:0] c);
        if (mc[1:0] == 2'h0) return 1'b1;
        if (mc[9]) return en[c];
        if (c[6:4] == {mc[6:5], 1'b0}) return en[{3'h0, c[3:0]}];
        if (c[6:4] == {mc[8:7], 1'b1}) return en[{3'h1, c[3:0]}];
        return 1'b0;
    endfunction

    // Reference channel counter in the link domain
    always @(posedge link_clk) begin
        if (link_fs) begin
            bc <= 3'h0;
            ch <= 7'h00;
        end else begin
            bc <= bc + 3'h1;
            if (bc == 3'h7) ch <= ch + 7'h01;
        end
        if (link_fs) chk_on <= arm;
        else if (!in_frame) chk_on <= 1'b0;
    end

    always @(negedge link_clk) begin
        if (chk_on) begin
            check("link_chan", {9'h0, ch}, {9'h0, link_chan});
            check("tx_chan_active", {15'h0, exp_act(tx_mc, tx_en, ch)}, {15'h0, tx_chan_active});
            check("rx_chan_active", {15'h0, exp_act(rx_mc, rx_en, ch)}, {15'h0, rx_chan_active});
        end
    end

    initial begin
        {reg_wr, reg_rd, gen_clk_out, arm, rst_n} = 5'h00;
        {reg_addr, reg_wdata, tx_mc, rx_mc, tx_en, rx_en} = '0;
        run = 1'b1;
        fails = 0;
        tests_run = 0;
        // Source code 00 only as the disabled case
        rows[0] = '{16'h0300, 16'h2000, 2'h1, 1'b1, 1'b0, 1'b0};
        rows[1] = '{16'h0380, 16'h0000, 2'h2, 1'b1, 1'b1, 1'b0};
        rows[2] = '{16'h0380, 16'h2000, 2'h3, 1'b1, 1'b0, 1'b1};
        rows[3] = '{16'h0000, 16'h0000, 2'h0, 1'b0, 1'b1, 1'b1};
        rows[4] = '{16'h0180, 16'h2000, 2'h3, 1'b1, 1'b0, 1'b1};
        // Long enough for four link clock edges
        repeat (40) @(posedge clk);
        rst_n <= 1'b1;
        run   <= 1'b0;
        rd(spcc_pkg::OFF_PIN_CONTROL, d);
        check("pin_control reset", 16'h0000, d & 16'hffef);
        rd(spcc_pkg::OFF_RATE_GEN_TWO, d);
        check("rate_gen_two reset", 16'h0000, d);
        rd(spcc_pkg::OFF_TX_MC_CTRL, d);
        check("tx_mc_ctrl reset", 16'h0000, d);
        check("oe_n reset", 16'h0003, {14'h0, rx_clk_oe_n, tx_clk_oe_n});
        $display("Test reset done");
        wait_idle();
        for (int i = 0; i < 5; i++) begin
            wr(spcc_pkg::OFF_PIN_CONTROL, rows[i].pc);
            wr(spcc_pkg::OFF_RATE_GEN_TWO, rows[i].rg);
            repeat (2) @(posedge clk);
            #1;
            check("gen_src_sel", {14'h0, rows[i].sel}, {14'h0, gen_src_sel});
            check("gen_src_valid", {15'h0, rows[i].vld}, {15'h0, gen_src_valid});
            check("rx_clk_oe_n", {15'h0, rows[i].rx_oe_n}, {15'h0, rx_clk_oe_n});
            check("tx_clk_oe_n", {15'h0, rows[i].tx_oe_n}, {15'h0, tx_clk_oe_n});
            if (rows[i].tx_oe_n === 1'b0)
                check("tx_clk_o", {15'h0, ~gen_clk_out}, {15'h0, tx_clk_o});
            rd(spcc_pkg::OFF_PIN_CONTROL, d);
            check("pin_control", rows[i].pc, d & spcc_pkg::PC_RW_MASK);
            rd(spcc_pkg::OFF_RATE_GEN_TWO, d);
            check("rate_gen_two", rows[i].rg, d);
        end
        $display("Test clock source rows done");
        wr(spcc_pkg::OFF_PIN_CONTROL, 16'hffff);
        rd(spcc_pkg::OFF_PIN_CONTROL, d);
        check("pin_control writable", spcc_pkg::PC_RW_MASK, d & 16'hffaf);
        check("rx data status", {15'h0, rx_data}, {15'h0, d[4]});
        check("clock pin status", {15'h0, tx_pin}, {15'h0, d[6]});
        wr(spcc_pkg::OFF_TX_MC_CTRL, 16'hffff);
        rd(spcc_pkg::OFF_TX_MC_CTRL, d);
        check("tx_mc_ctrl writable", spcc_pkg::MC_RW_MASK, d & 16'hffe3);
        wr(spcc_pkg::OFF_RX_MC_CTRL, 16'hffff);
        rd(spcc_pkg::OFF_RX_MC_CTRL, d);
        check("rx_mc_ctrl writable", spcc_pkg::MC_RW_MASK, d & 16'hffe3);
        // Write and read back with no gap between the strobes
        reg_addr  <= spcc_pkg::OFF_RATE_GEN_TWO;
        reg_wdata <= 16'h5a5a;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        check("rate_gen_two back to back", 16'h5a5a, d);
        @(posedge clk);
        wr(8'hfe, 16'hffff);
        rd(8'hfe, d);
        check("unmapped read", 16'h0000, d);
        $display("Test register access done");
        tx_mc = 16'h0201;
        rx_mc = 16'h00a1;
        wr(spcc_pkg::OFF_TX_MC_CTRL, tx_mc);
        wr(spcc_pkg::OFF_RX_MC_CTRL, rx_mc);
        wr_en(1'b1, 3'h7, 16'h8000);
        wr_en(1'b1, 3'h2, 16'h0001);
        wr_en(1'b1, 3'h0, 16'h0020);
        wr_en(1'b0, 3'h0, 16'h0008);
        wr_en(1'b0, 3'h1, 16'h0001);
        wr_en(1'b0, 3'h2, 16'h0001);
        run_frame("extended tx and partitioned rx");
        rx_mc = 16'h0000;
        wr(spcc_pkg::OFF_RX_MC_CTRL, rx_mc);
        run_frame("rx all channels");
        give_verdict();
    end
endmodule
